// >>> inc/rhp_pkg.sv
// Constants, field positions, timing and state type of the root hub
// port state and change registers.
// Assumes a 10 MHz clock and byte addresses on the register port.
package rhp_pkg;

  // Port count and register map
  localparam int          PORT_COUNT    = 4;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  PORT_BASE_OFS = 8'h54;
  localparam int          PORT_STRIDE   = 4;
  localparam logic [7:0]  INT_STAT_OFS  = 8'h70;
  localparam logic [7:0]  INT_MASK_OFS  = 8'h74;
  localparam logic [31:0] PORT_RESET_VAL = 32'h0000_0000;
  localparam logic [3:0]  INT_RESET_VAL  = 4'h0;

  // Present state fields, lower half-word
  localparam int CCS_BIT    = 0;
  localparam int ENB_BIT    = 1;
  localparam int SUSP_BIT   = 2;
  localparam int OVC_BIT    = 3;
  localparam int RST_BIT    = 4;
  localparam int PWR_BIT    = 8;
  localparam int LOWSPD_BIT = 9;

  // Change flags, upper half-word
  localparam int CONN_CHG_BIT = 16;
  localparam int ENB_CHG_BIT  = 17;
  localparam int SUSP_CHG_BIT = 18;
  localparam int OVC_CHG_BIT  = 19;
  localparam int RST_CHG_BIT  = 20;

  // Write commands, lower half-word, write 1 to act
  localparam int          CMD_W        = 10;
  localparam int          CMD_CLR_EN   = 0;
  localparam int          CMD_SET_EN   = 1;
  localparam int          CMD_SET_SUSP = 2;
  localparam int          CMD_CLR_SUSP = 3;
  localparam int          CMD_SET_RST  = 4;
  localparam int          CMD_SET_PWR  = 8;
  localparam int          CMD_CLR_PWR  = 9;
  localparam logic [9:0]  CMD_MASK     = 10'h31f;

  // Timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int PORT_RESET_TIME_MS = 10;
  localparam int RESUME_TIME_MS     = 20;
  localparam int RESYNC_TIME_MS     = 3;
  localparam int LS_EOP_TIME_NS     = 1334;
  localparam int PORT_RESET_CYCLES  =
    (PORT_RESET_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_CYCLES      =
    (RESUME_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESYNC_CYCLES      =
    (RESYNC_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LS_EOP_CYCLES      =
    (LS_EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W              = 24;

  // Per-port signalling sequencer
  typedef enum logic [2:0] {
    PS_IDLE,
    PS_RESET,
    PS_RESUME,
    PS_EOP,
    PS_RESYNC
  } rhp_port_e;

endpackage

// >>> src/rhp_sticky_flag.sv
// One sticky flag: set by a hardware event, cleared by software.
// Assumes set and clear are one-cycle pulses in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module rhp_sticky_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Event and clear
  input  wire logic setPulse,
  input  wire logic clrPulse,
  // Flag
  output var  logic flag
);

  logic flagNxt;

  // Set beats a clear in the same cycle so no event is lost
  assign flagNxt = setPulse | (flag & ~clrPulse);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else begin
      flag <= flagNxt;
    end
  end

endmodule
`default_nettype wire

// >>> src/rhp_root_hub_ports.sv
// Root hub port state and change registers for all downstream ports.
// Assumes a single-cycle register port and port inputs synchronous to clk.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rhp_root_hub_ports #(
  parameter int RESET_CYCLES  = rhp_pkg::PORT_RESET_CYCLES,
  parameter int RESUME_CYCLES = rhp_pkg::RESUME_CYCLES,
  parameter int RESYNC_CYCLES = rhp_pkg::RESYNC_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [31:0] regRdata,
  // Port line status
  input  wire logic [3:0]  devConnected,
  input  wire logic [3:0]  devLowSpeed,
  input  wire logic [3:0]  portOvercurrent,
  input  wire logic [3:0]  hwPortDisable,
  input  wire logic [3:0]  remoteWake,
  input  wire logic [3:0]  txnBusy,
  // Port signalling
  output var  logic [3:0]  portResetDrive,
  output var  logic [3:0]  portResumeDrive,
  output var  logic [3:0]  portEopDrive,
  output var  logic [3:0]  portPowerOn,
  // Interrupt
  output var  logic        irq
);

  localparam int NP = rhp_pkg::PORT_COUNT;
  localparam int CW = rhp_pkg::CNT_W;

  // Shared decode
  logic        intStatRd;
  logic        intMaskWr;
  logic        intMaskHit;
  logic [3:0]  intStat;
  logic [3:0]  intMask_r;
  logic [3:0]  intMask_nxt;
  logic [3:0]  portEvent;
  logic [31:0] rdChain [NP+1];
  logic [31:0] regRdata_nxt;
  logic        irq_nxt;
  logic [3:0]  rstDrvVec;
  logic [3:0]  resDrvVec;
  logic [3:0]  eopDrvVec;
  logic [3:0]  pwrVec;

  assign intStatRd  = regRd && (regAddr == rhp_pkg::INT_STAT_OFS);
  assign intMaskHit = regAddr == rhp_pkg::INT_MASK_OFS;
  assign intMaskWr  = regWr && intMaskHit;
  assign rdChain[0] = 32'h0000_0000;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      localparam logic [7:0] PORT_OFS =
        8'(int'(rhp_pkg::PORT_BASE_OFS) + rhp_pkg::PORT_STRIDE * gp);

      rhp_pkg::rhp_port_e st_r;
      rhp_pkg::rhp_port_e st_nxt;
      logic [CW-1:0]      cnt_r;
      logic [CW-1:0]      cnt_nxt;
      logic [9:0]         pend_r;
      logic [9:0]         pend_nxt;
      logic               ccs_r;
      logic               enb_r;
      logic               susp_r;
      logic               ovc_r;
      logic               rstAct_r;
      logic               pwr_r;
      logic               lowSpd_r;
      logic               enb_nxt;
      logic               susp_nxt;
      logic               rstAct_nxt;
      logic               pwr_nxt;
      logic               lowSpd_nxt;
      logic               drvRst_r;
      logic               drvRes_r;
      logic               drvEop_r;
      logic               portHit;
      logic               portWr;
      logic               applyCmd;
      logic               cmdClrEn;
      logic               cmdSetEn;
      logic               cmdSetSusp;
      logic               cmdClrSusp;
      logic               cmdSetRst;
      logic               cmdSetPwr;
      logic               cmdClrPwr;
      logic               badCmd;
      logic               attachEv;
      logic               connChgSet;
      logic               hwDis;
      logic               ovcChgSet;
      logic               cntZero;
      logic               rstDone;
      logic               resDone;
      logic               startRst;
      logic               startRes;
      logic               connChg;
      logic               enbChg;
      logic               suspChg;
      logic               ovcChg;
      logic               rstChg;
      logic               suspChgClr;
      logic [31:0]        portWord;

      // Register decode
      assign portHit = regAddr == PORT_OFS;
      assign portWr  = regWr && portHit;

      // Commands wait in pend_r while a transaction runs on the port
      assign applyCmd   = (|pend_r) && !txnBusy[gp];
      assign cmdClrEn   = applyCmd && pend_r[rhp_pkg::CMD_CLR_EN];
      assign cmdSetEn   = applyCmd && pend_r[rhp_pkg::CMD_SET_EN];
      assign cmdSetSusp = applyCmd && pend_r[rhp_pkg::CMD_SET_SUSP];
      assign cmdClrSusp = applyCmd && pend_r[rhp_pkg::CMD_CLR_SUSP];
      assign cmdSetRst  = applyCmd && pend_r[rhp_pkg::CMD_SET_RST];
      assign cmdSetPwr  = applyCmd && pend_r[rhp_pkg::CMD_SET_PWR];
      assign cmdClrPwr  = applyCmd && pend_r[rhp_pkg::CMD_CLR_PWR];
      // Reserved write bits are masked so stray ones cannot act
      assign pend_nxt = (applyCmd ? 10'h000 : pend_r)
                      | (portWr ? (regWdata[9:0] & rhp_pkg::CMD_MASK)
                                : 10'h000);

      // Hardware events
      assign attachEv = devConnected[gp] != ccs_r;
      assign badCmd   = !ccs_r && (cmdSetRst || cmdSetEn || cmdSetSusp);
      assign connChgSet = attachEv || badCmd;
      assign hwDis    = enb_r && (hwPortDisable[gp] || !devConnected[gp]);
      assign ovcChgSet  = ovc_r != portOvercurrent[gp];
      assign cntZero  = cnt_r == '0;
      assign rstDone  = (st_r == rhp_pkg::PS_RESET) && cntZero;
      assign resDone  = (st_r == rhp_pkg::PS_RESYNC) && cntZero;
      assign startRst = cmdSetRst && ccs_r && (st_r == rhp_pkg::PS_IDLE);
      assign startRes = (st_r == rhp_pkg::PS_IDLE) && susp_r && !startRst
                      && (cmdClrSusp || remoteWake[gp]);

      // Signalling sequencer
      always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cntZero ? cnt_r : cnt_r - 1'b1;
        case (st_r)
          rhp_pkg::PS_IDLE: begin
            if (startRst) begin
              st_nxt  = rhp_pkg::PS_RESET;
              cnt_nxt = CW'(RESET_CYCLES - 1);
            end else if (startRes) begin
              st_nxt  = rhp_pkg::PS_RESUME;
              cnt_nxt = CW'(RESUME_CYCLES - 1);
            end
          end
          rhp_pkg::PS_RESET: begin
            if (cntZero) begin
              st_nxt = rhp_pkg::PS_IDLE;
            end
          end
          rhp_pkg::PS_RESUME: begin
            if (cntZero) begin
              st_nxt  = rhp_pkg::PS_EOP;
              cnt_nxt = CW'(rhp_pkg::LS_EOP_CYCLES - 1);
            end
          end
          rhp_pkg::PS_EOP: begin
            if (cntZero) begin
              st_nxt  = rhp_pkg::PS_RESYNC;
              cnt_nxt = CW'(RESYNC_CYCLES - 1);
            end
          end
          rhp_pkg::PS_RESYNC: begin
            if (cntZero) begin
              st_nxt = rhp_pkg::PS_IDLE;
            end
          end
          default: begin
            st_nxt  = rhp_pkg::PS_IDLE;
            cnt_nxt = '0;
          end
        endcase
      end

      // Present state next values
      assign enb_nxt    = hwDis ? 1'b0
                        : rstDone ? 1'b1
                        : cmdClrEn ? 1'b0
                        : (cmdSetEn && ccs_r) ? 1'b1
                        : enb_r;
      assign susp_nxt   = (rstDone || resDone || !devConnected[gp]) ? 1'b0
                        : (cmdSetSusp && ccs_r && enb_r) ? 1'b1
                        : susp_r;
      assign rstAct_nxt = startRst ? 1'b1 : (rstDone ? 1'b0 : rstAct_r);
      assign pwr_nxt    = cmdSetPwr ? 1'b1 : (cmdClrPwr ? 1'b0 : pwr_r);
      assign lowSpd_nxt = devConnected[gp] && devLowSpeed[gp];

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          st_r     <= rhp_pkg::PS_IDLE;
          cnt_r    <= '0;
          pend_r   <= 10'h000;
          ccs_r    <= 1'b0;
          enb_r    <= 1'b0;
          susp_r   <= 1'b0;
          ovc_r    <= 1'b0;
          rstAct_r <= 1'b0;
          pwr_r    <= 1'b0;
          lowSpd_r <= 1'b0;
          drvRst_r <= 1'b0;
          drvRes_r <= 1'b0;
          drvEop_r <= 1'b0;
        end else begin
          st_r     <= st_nxt;
          cnt_r    <= cnt_nxt;
          pend_r   <= pend_nxt;
          ccs_r    <= devConnected[gp];
          enb_r    <= enb_nxt;
          susp_r   <= susp_nxt;
          ovc_r    <= portOvercurrent[gp];
          rstAct_r <= rstAct_nxt;
          pwr_r    <= pwr_nxt;
          lowSpd_r <= lowSpd_nxt;
          drvRst_r <= st_nxt == rhp_pkg::PS_RESET;
          drvRes_r <= st_nxt == rhp_pkg::PS_RESUME;
          drvEop_r <= st_nxt == rhp_pkg::PS_EOP;
        end
      end

      // Change flags; software clears by writing one
      assign suspChgClr = (portWr && regWdata[rhp_pkg::SUSP_CHG_BIT])
                        || rstDone;

      rhp_sticky_flag u_connChg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (connChgSet),
        .clrPulse (portWr && regWdata[rhp_pkg::CONN_CHG_BIT]),
        .flag     (connChg)
      );

      rhp_sticky_flag u_enbChg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (hwDis),
        .clrPulse (portWr && regWdata[rhp_pkg::ENB_CHG_BIT]),
        .flag     (enbChg)
      );

      rhp_sticky_flag u_suspChg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (resDone),
        .clrPulse (suspChgClr),
        .flag     (suspChg)
      );

      rhp_sticky_flag u_ovcChg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (ovcChgSet),
        .clrPulse (portWr && regWdata[rhp_pkg::OVC_CHG_BIT]),
        .flag     (ovcChg)
      );

      rhp_sticky_flag u_rstChg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (rstDone),
        .clrPulse (portWr && regWdata[rhp_pkg::RST_CHG_BIT]),
        .flag     (rstChg)
      );

      // Register image; reserved bits read zero
      always_comb begin
        portWord = rhp_pkg::PORT_RESET_VAL;
        portWord[rhp_pkg::CCS_BIT]      = ccs_r;
        portWord[rhp_pkg::ENB_BIT]      = enb_r;
        portWord[rhp_pkg::SUSP_BIT]     = susp_r;
        portWord[rhp_pkg::OVC_BIT]      = ovc_r;
        portWord[rhp_pkg::RST_BIT]      = rstAct_r;
        portWord[rhp_pkg::PWR_BIT]      = pwr_r;
        portWord[rhp_pkg::LOWSPD_BIT]   = lowSpd_r;
        portWord[rhp_pkg::CONN_CHG_BIT] = connChg;
        portWord[rhp_pkg::ENB_CHG_BIT]  = enbChg;
        portWord[rhp_pkg::SUSP_CHG_BIT] = suspChg;
        portWord[rhp_pkg::OVC_CHG_BIT]  = ovcChg;
        portWord[rhp_pkg::RST_CHG_BIT]  = rstChg;
      end

      assign rdChain[gp+1] = rdChain[gp] | (portHit ? portWord : 32'h0);
      assign portEvent[gp] = connChgSet || hwDis || resDone || ovcChgSet
                           || rstDone;
      assign rstDrvVec[gp] = drvRst_r;
      assign resDrvVec[gp] = drvRes_r;
      assign eopDrvVec[gp] = drvEop_r;
      assign pwrVec[gp]    = pwr_r;

      // Interrupt status bit; cleared by reading the status register
      rhp_sticky_flag u_int (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setPulse (portEvent[gp]),
        .clrPulse (intStatRd),
        .flag     (intStat[gp])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  assign regRdata_nxt = !regRd ? 32'h0000_0000
                      : intStatRd ? {28'h0000000, intStat}
                      : intMaskHit ? {28'h0000000, intMask_r}
                      : rdChain[NP];
  assign intMask_nxt  = intMaskWr ? regWdata[3:0] : intMask_r;
  // Taken from the next status so irq drops with the read that clears it
  assign irq_nxt = |(intMask_nxt & (portEvent
                 | (intStat & {4{~intStatRd}})));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata  <= 32'h0000_0000;
      intMask_r <= rhp_pkg::INT_RESET_VAL;
      irq       <= 1'b0;
    end else begin
      regRdata  <= regRdata_nxt;
      intMask_r <= intMask_nxt;
      irq       <= irq_nxt;
    end
  end

  assign portResetDrive  = rstDrvVec;
  assign portResumeDrive = resDrvVec;
  assign portEopDrive    = eopDrvVec;
  assign portPowerOn     = pwrVec;

endmodule
`default_nettype wire

// >>> sim/rhp_root_hub_ports_asserts.sv
// Assertions on the root hub port block, attached by bind.
// Assumes port 0 carries the signalling traffic under test.
`timescale 1ns/100ps
`default_nettype none
module rhp_root_hub_ports_asserts #(
  parameter int RESET_CYCLES  = 20,
  parameter int RESUME_CYCLES = 30,
  parameter int RESYNC_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // Port side
  input wire logic [3:0]  txnBusy,
  input wire logic [3:0]  portResetDrive,
  input wire logic [3:0]  portResumeDrive,
  input wire logic [3:0]  portEopDrive,
  input wire logic [3:0]  portPowerOn,
  input wire logic        irq
);
  localparam int RST_HI = RESET_CYCLES - 1;
  localparam int RSM_HI = RESUME_CYCLES - 1;
  wire clrReq = (regRd && regAddr == rhp_pkg::INT_STAT_OFS) ||
                (regWr && regAddr == rhp_pkg::INT_MASK_OFS);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Low-speed end of packet lasts 14 cycles
  sequence s_eop;
    portEopDrive[0] [*8] ##1 portEopDrive[0] [*6] ##1 !portEopDrive[0];
  endsequence
  property p_rd_idle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rsvd;
    (regRdata & 32'hffe0_fce0) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read as one");
  property p_rst_len;
    $rose(portResetDrive[0]) |->
      ##RST_HI portResetDrive[0] ##1 !portResetDrive[0];
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("port reset length");
  property p_rst_gate;
    $rose(portResetDrive[0]) |-> !$past(txnBusy[0]);
  endproperty
  a_rst_gate: assert property (p_rst_gate)
    else $error("reset began during transaction");
  property p_pwr_gate;
    $rose(portPowerOn[0]) |-> !$past(txnBusy[0]);
  endproperty
  a_pwr_gate: assert property (p_pwr_gate)
    else $error("power changed during transaction");
  property p_rsm_len;
    $rose(portResumeDrive[0]) |->
      ##RSM_HI portResumeDrive[0] ##1 !portResumeDrive[0];
  endproperty
  a_rsm_len: assert property (p_rsm_len)
    else $error("resume pulse length");
  property p_eop;
    $fell(portResumeDrive[0]) |-> s_eop;
  endproperty
  a_eop: assert property (p_eop)
    else $error("end of packet after resume");
  // Interrupt only drops after a status read or a mask write
  property p_irq_fall;
    $fell(irq) |-> $past(clrReq) || $past(clrReq, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without clear");
endmodule

bind rhp_root_hub_ports rhp_root_hub_ports_asserts #(
  .RESET_CYCLES (RESET_CYCLES),
  .RESUME_CYCLES(RESUME_CYCLES),
  .RESYNC_CYCLES(RESYNC_CYCLES)
) u_chk (
  .clk, .sys_rst, .regAddr, .regWr, .regRd, .regRdata, .txnBusy,
  .portResetDrive, .portResumeDrive, .portEopDrive, .portPowerOn, .irq
);
`default_nettype wire

// >>> sim/rhp_usb_dev_model.sv
// Behavioural model of the devices on the four downstream ports.
// Assumes the bench sets line conditions; a transaction lasts TXN_CYCLES.
`timescale 1ns/100ps
`default_nettype none
module rhp_usb_dev_model #(
  parameter int TXN_CYCLES = 12
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Bench controls
  input  wire logic [3:0] plugIn,
  input  wire logic [3:0] lowSpd,
  input  wire logic [3:0] ocFault,
  input  wire logic [3:0] babble,
  input  wire logic [3:0] wakeReq,
  input  wire logic [3:0] txnStart,
  // Hub signalling
  input  wire logic [3:0] portResumeDrive,
  // Line status
  output var  logic [3:0] devConnected,
  output var  logic [3:0] devLowSpeed,
  output var  logic [3:0] portOvercurrent,
  output var  logic [3:0] hwPortDisable,
  output var  logic [3:0] remoteWake,
  output var  logic [3:0] txnBusy
);
  int txnCnt [4];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {devConnected, devLowSpeed, portOvercurrent} <= '0;
      {hwPortDisable, remoteWake, txnBusy} <= '0;
      for (int p = 0; p < 4; p++) txnCnt[p] = 0;
    end else begin
      devConnected <= plugIn;
      // An empty port shows no speed, the line idles low
      devLowSpeed <= plugIn & lowSpd;
      portOvercurrent <= ocFault;
      hwPortDisable <= babble & plugIn;
      // Wake request held until the hub answers with resume
      remoteWake <= (remoteWake | wakeReq) & ~portResumeDrive;
      for (int p = 0; p < 4; p++) begin
        if (txnStart[p]) txnCnt[p] = TXN_CYCLES;
        else if (txnCnt[p] > 0) txnCnt[p]--;
        txnBusy[p] <= (txnCnt[p] > 0);
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/test_root_hub_port_status.sv
// Self-checking bench for the root hub port state and change registers.
// Assumes the device model drives the port lines; short signalling counts.
`timescale 1ns/100ps
`default_nettype none
module test_root_hub_port_status;
  localparam int RST_C = 20;
  localparam int RSM_C = 30;
  localparam int SYN_C = 10;
  localparam logic [7:0] P0  = rhp_pkg::PORT_BASE_OFS;
  localparam logic [7:0] P1  = P0 + 8'h04;
  localparam logic [7:0] P2  = P0 + 8'h08;
  localparam logic [7:0] STS = rhp_pkg::INT_STAT_OFS;
  localparam logic [7:0] MSK = rhp_pkg::INT_MASK_OFS;
  logic        clk, sys_rst, regWr, regRd, irq;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [3:0]  plugIn, lowSpd, ocFault, babble, wakeReq, txnStart;
  logic [3:0]  devConnected, devLowSpeed, portOvercurrent, hwPortDisable;
  logic [3:0]  remoteWake, txnBusy, portResetDrive, portResumeDrive;
  logic [3:0]  portEopDrive, portPowerOn;
  int          err_total, tests_run, cycles;

  always #50 clk = ~clk;

  rhp_usb_dev_model u_dev (.clk, .sys_rst, .plugIn, .lowSpd, .ocFault,
    .babble, .wakeReq, .txnStart, .portResumeDrive, .devConnected,
    .devLowSpeed, .portOvercurrent, .hwPortDisable, .remoteWake, .txnBusy);
  rhp_root_hub_ports #(.RESET_CYCLES(RST_C), .RESUME_CYCLES(RSM_C),
    .RESYNC_CYCLES(SYN_C)) dut (.clk, .sys_rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .devConnected, .devLowSpeed,
    .portOvercurrent, .hwPortDisable, .remoteWake, .txnBusy,
    .portResetDrive, .portResumeDrive, .portEopDrive, .portPowerOn, .irq);

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lchk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: level %b expected %b", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic waitfall(input int n);
    repeat (n) @(posedge clk) if (!portResetDrive[0]) break;
    lchk(portResetDrive[0], 1'b0);
    cyc(1);
  endtask

  task automatic t_map();
    for (int p = 0; p < 4; p++) rchk(P0 + 8'(4 * p), 32'h0);
    wr(8'h64, 32'h0000_0300);
    rchk(8'h64, 32'h0);
    $display("map done");
  endtask
  task automatic t_attach();
    plugIn[0] <= 1'b1;
    lowSpd[0] <= 1'b1;
    cyc(4);
    rchk(P0, 32'h0001_0201);
    wr(P0, 32'h0);
    rchk(P0, 32'h0001_0201);
    wr(P0, 32'h0001_0000);
    rchk(P0, 32'h0000_0201);
    lchk(irq, 1'b0);
    rchk(STS, 32'h1);
    rchk(STS, 32'h0);
    $display("attach done");
  endtask
  task automatic t_absent();
    logic [31:0] cmds [3] = '{32'h2, 32'h4, 32'h10};
    for (int i = 0; i < 3; i++) begin
      wr(P1, cmds[i]);
      cyc(3);
      rchk(P1, 32'h0001_0000);
      wr(P1, 32'h0001_0000);
    end
    $display("absent done");
  endtask
  task automatic t_reset();
    txnStart[0] <= 1'b1;
    @(posedge clk);
    txnStart[0] <= 1'b0;
    wr(P0, 32'h0000_0110);
    rchk(P0, 32'h0000_0201);
    repeat (20) @(posedge clk) if (!txnBusy[0]) break;
    cyc(3);
    rchk(P0, 32'h0000_0311);
    waitfall(RST_C + 5);
    rchk(P0, 32'h0010_0303);
    $display("reset done");
  endtask
  task automatic t_resume();
    wr(P0, 32'h4);
    cyc(3);
    rchk(P0, 32'h0010_0307);
    wr(P0, 32'h8);
    repeat (RSM_C + 30) @(posedge clk) if (portEopDrive[0]) break;
    repeat (20) @(posedge clk) if (!portEopDrive[0]) break;
    rchk(P0, 32'h0010_0307);
    cyc(SYN_C + 2);
    rchk(P0, 32'h0014_0303);
    wr(P0, 32'h0004_0004);
    cyc(3);
    rchk(P0, 32'h0010_0307);
    wakeReq[0] <= 1'b1;
    @(posedge clk);
    wakeReq[0] <= 1'b0;
    cyc(RSM_C + rhp_pkg::LS_EOP_CYCLES + SYN_C + 4);
    rchk(P0, 32'h0014_0303);
    wr(P0, 32'h10);
    cyc(3);
    waitfall(RST_C + 5);
    rchk(P0, 32'h0010_0303);
    $display("resume done");
  endtask
  task automatic t_hwdis();
    wr(P0, 32'h0010_0001);
    cyc(3);
    rchk(P0, 32'h0000_0301);
    wr(P0, 32'h2);
    cyc(3);
    rchk(P0, 32'h0000_0303);
    babble[0] <= 1'b1;
    @(posedge clk);
    babble[0] <= 1'b0;
    cyc(3);
    rchk(P0, 32'h0002_0301);
    plugIn[0] <= 1'b0;
    cyc(4);
    rchk(P0, 32'h0003_0100);
    wr(P0, 32'h0000_0200);
    cyc(3);
    rchk(P0, 32'h0003_0000);
    $display("disable done");
  endtask
  task automatic t_ovc();
    rchk(STS, 32'h3);
    wr(MSK, 32'h4);
    ocFault[2] <= 1'b1;
    cyc(4);
    rchk(P2, 32'h0008_0008);
    lchk(irq, 1'b1);
    rchk(STS, 32'h4);
    cyc(2);
    lchk(irq, 1'b0);
    ocFault[2] <= 1'b0;
    cyc(4);
    rchk(P2, 32'h0008_0000);
    wr(P2, 32'h0008_0000);
    rchk(P2, 32'h0);
    $display("overcurrent done");
  endtask
  // Reset in mid-run with an interrupt pending and a mask set
  task automatic t_rerst();
    @(posedge clk);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rchk(MSK, 32'h0);
    rchk(STS, 32'h0);
    lchk(irq, 1'b0);
    $display("reset again done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {regWr, regRd, regAddr, regWdata} = '0;
    {plugIn, lowSpd, ocFault, babble, wakeReq, txnStart} = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_map();
    t_attach();
    t_absent();
    t_reset();
    t_resume();
    t_hwdis();
    t_ovc();
    t_rerst();
    conclude();
  end
endmodule
`default_nettype wire
